// [hdl/ics_map.svh]
// Named constants for the command slave: command codes and counts.
// Assumes inclusion by bare name from the command slave sources.
`ifndef ICS_MAP_SVH
`define ICS_MAP_SVH
// ****************************************************************
// Command codes carried in the low four address bits
// ****************************************************************
`define ICS_CMD_INSTRUCTION_CMD 4'h1
`define ICS_CMD_ADDR_HI 4'h2
`define ICS_CMD_ADDR_LO 4'h3
`define ICS_CMD_DIR_WR 4'h4
`define ICS_CMD_DIR_RD 4'h5
`define ICS_CMD_IDX_WR 4'h6
`define ICS_CMD_IDX_RD 4'h7
`define ICS_CMD_OFF_WR 4'h8
`define ICS_CMD_OFF_RD 4'h9
// ****************************************************************
// Counts and fixed values
// ****************************************************************
`define ICS_BIT_LAST 4'h8
`define ICS_BIT_FIRST 4'h0
`define ICS_CMD_STEP 4'h1
`define ICS_BIT_STEP 4'h1
`define ICS_OFF_STEP 8'h01
`define ICS_ZERO_BYTE 8'h00
`define ICS_ZERO_ADDR 16'h0000
`endif

// [hdl/ics_pkg.sv]
// Types shared by the command slave and its line synchroniser.
// Assumes a SystemVerilog-2012 tool flow.
package ics_pkg;
  // Slave protocol states.
  typedef enum logic [2:0] {
    ICS_IDLE = 3'b000,
    ICS_ADDR = 3'b001,
    ICS_AACK = 3'b010,
    ICS_WDATA = 3'b011,
    ICS_WACK = 3'b100,
    ICS_RDATA = 3'b101,
    ICS_RACK = 3'b110,
    ICS_RHOLD = 3'b111
  } ics_state_t;
  // One access toward the internal register and memory space.
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ics_mem_req_t;
  // Synchronised bus lines, pads and the bus events found on them.
  typedef struct packed {
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic sda;
    logic adv;
    logic [2:0] chip;
  } ics_line_t;
endpackage

// [hdl/ics_line_sync.sv]
// Two-flop synchronisers for the bus lines and pads, plus edge,
// start and stop detection. Assumes pins are asynchronous to i_clk.
`timescale 1ns/1ps
module ics_line_sync
  import ics_pkg::*;
#(
  parameter int CHIP_W = 3
)
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic [CHIP_W-1:0] i_chip,
  input wire logic i_adv,
  output ics_line_t o_line
);
  localparam int W = CHIP_W + 3;
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic scl_old_q;
  logic sda_old_q;
  logic scl_s;
  logic sda_s;
  // ****************************************************************
  // Synchroniser; the first stage feeds only the second.
  // ****************************************************************
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      s1_q <= '1;
      s2_q <= '1;
      scl_old_q <= 1'b1;
      sda_old_q <= 1'b1;
    end
    else
    begin
      s1_q <= {i_scl, i_sda, i_adv, i_chip};
      s2_q <= s1_q;
      scl_old_q <= scl_s;
      sda_old_q <= sda_s;
    end
  end
  // Events are taken from the second stage and its delayed copy.
  assign scl_s = s2_q[W-1];
  assign sda_s = s2_q[W-2];
  assign o_line.scl_rise = scl_s & ~scl_old_q;
  assign o_line.scl_fall = ~scl_s & scl_old_q;
  assign o_line.start = scl_s & scl_old_q & sda_old_q & ~sda_s;
  assign o_line.stop = scl_s & scl_old_q & ~sda_old_q & sda_s;
  assign o_line.sda = sda_s;
  assign o_line.adv = s2_q[W-3];
  assign o_line.chip = s2_q[CHIP_W-1:0];
endmodule // ics_line_sync

// [hdl/ics_command_slave.sv]
// Two-wire bus slave that turns addressed commands into accesses to
// an internal 16-bit space. Assumes the space answers a read in the
// same cycle as o_mem_req.rd, and an external open-drain pad cell.
// Function
// [RULE_01] Slave with 7-bit addressing, rates under 1 Mbit/s.
// [RULE_02] Address splits into 3-bit chip selector and 4-bit command.
// [RULE_03] Answer only when selector bits equal the chip pad value.
// [RULE_04] Each command carries exactly one parameter byte.
// [RULE_05] Command 2 loads address high byte, command 3 low byte.
// [RULE_06] Command 4 writes at the address, command 5 reads there.
// [RULE_07] Direct accesses repeat on one location until address reloads.
// [RULE_08] Commands 6 and 7 access address plus offset, then offset+1.
// [RULE_09] Command 8 loads the offset, command 9 returns it.
// [RULE_10] Command 1 issues an instruction byte; reading it gives zero.
// [RULE_11] Unused command codes cause no action.
// [RULE_12] Mode pad low repeats commands, high advances commands.
// [RULE_13] Repeat mode runs the same command for each further byte.
// [RULE_14] Advance mode runs command plus one for each further byte.
// [RULE_15] Multi-byte and single-byte sequences give identical results.
// [RULE_16] Indexed location is address plus offset, modulo 16 bits.
// [RULE_17] Acknowledge bytes; send reads MSB first; stop on master NACK.
`timescale 1ns/1ps
`include "ics_map.svh"
module ics_command_slave
  import ics_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic [2:0] i_chip_select_code,
  input wire logic i_auto_advance_pad,
  input wire logic [7:0] i_mem_rdata,
  output logic o_sda_o,
  output logic o_sda_oe,
  output ics_mem_req_t o_mem_req,
  output logic o_instruction_cmd_valid,
  output logic [7:0] o_instruction_cmd_byte
);
  ics_line_t ev;
  ics_state_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, tx_q, off_q, instruction_cmd_q;
  logic [15:0] addr_q;
  logic [3:0] cmd_q, cmd_nx, prep_cmd;
  logic rw_q, ld_q, instruction_cmd_v_q;
  ics_mem_req_t mem_q;
  logic addr_done, match, rack_ok, rd_prep, wr_exec, rd_done, wack_end;
  logic shifting;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Indexed commands add the offset; the sum wraps at 16 bits.
  function automatic logic [15:0] target(input logic [3:0] c,
    input logic [15:0] a, input logic [7:0] o);
    if (c == `ICS_CMD_IDX_WR || c == `ICS_CMD_IDX_RD)
      target = a + {8'h00, o}; // see [RULE_16]
    else
      target = a; // see [RULE_07]
  endfunction

  // Byte returned to the master for a read of command c.
  function automatic logic [7:0] read_sel(input logic [3:0] c,
    input logic [7:0] rd, input logic [7:0] o, input logic [15:0] a);
    case (c)
      `ICS_CMD_DIR_RD, `ICS_CMD_IDX_RD: read_sel = rd; // see [RULE_06]
      `ICS_CMD_OFF_RD: read_sel = o; // see [RULE_09]
      `ICS_CMD_ADDR_HI: read_sel = a[15:8];
      `ICS_CMD_ADDR_LO: read_sel = a[7:0];
      default: read_sel = `ICS_ZERO_BYTE; // see [RULE_10]
    endcase
  endfunction

  ics_line_sync #(.CHIP_W(3)) u_sync (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .i_chip(i_chip_select_code),
    .i_adv(i_auto_advance_pad),
    .o_line(ev)
  );

  // ****************************************************************
  // Event decode
  // ****************************************************************
  // Bit counting runs on SCL rises; the phase moves on at SCL falls, except RACK, which ends on a rise.
  assign shifting = (st_q == ICS_ADDR) || (st_q == ICS_WDATA) ||
                    (st_q == ICS_RDATA);
  assign addr_done = (st_q == ICS_ADDR) && ev.scl_fall &&
                     (cnt_q == `ICS_BIT_LAST); // see [RULE_01]
  assign match = (sh_q[7:5] == ev.chip); // see [RULE_03]
  assign rack_ok = (st_q == ICS_RACK) && ev.scl_rise && !ev.sda;
  assign wr_exec = (st_q == ICS_WDATA) && ev.scl_fall &&
                   (cnt_q == `ICS_BIT_LAST); // see [RULE_04]
  assign rd_done = (st_q == ICS_RDATA) && ev.scl_fall &&
                   (cnt_q == `ICS_BIT_LAST);
  assign wack_end = (st_q == ICS_WACK) && ev.scl_fall;
  // The pad picks repeat or advance for every further byte.
  assign cmd_nx = ev.adv ? cmd_q + `ICS_CMD_STEP : cmd_q; // see [RULE_12]
  assign rd_prep = (addr_done && match && sh_q[0]) || rack_ok;
  assign prep_cmd = addr_done ? sh_q[4:1] : cmd_nx; // see [RULE_02]
  // Drive low only for acknowledge and for zero data bits.
  assign o_sda_o = 1'b0;
  assign o_sda_oe = (st_q == ICS_AACK) || (st_q == ICS_WACK) ||
                    ((st_q == ICS_RDATA) && !tx_q[7]); // see [RULE_17]
  assign o_mem_req = mem_q;
  assign o_instruction_cmd_valid = instruction_cmd_v_q;
  assign o_instruction_cmd_byte = instruction_cmd_q;

  // ****************************************************************
  // Protocol state machine
  // ****************************************************************
  // Start and stop override every phase so an aborted frame recovers.
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      ICS_ADDR: if (addr_done) st_d = match ? ICS_AACK : ICS_IDLE;
      ICS_AACK: if (ev.scl_fall) st_d = rw_q ? ICS_RDATA : ICS_WDATA;
      ICS_WDATA: if (wr_exec) st_d = ICS_WACK;
      ICS_WACK: if (ev.scl_fall) st_d = ICS_WDATA;
      ICS_RDATA: if (rd_done) st_d = ICS_RACK;
      ICS_RACK:
        if (ev.scl_rise)
          st_d = ev.sda ? ICS_IDLE : ICS_RHOLD; // see [RULE_17]
      ICS_RHOLD: if (ev.scl_fall) st_d = ICS_RDATA;
      default: st_d = st_q;
    endcase
    if (ev.stop)
      st_d = ICS_IDLE;
    if (ev.start)
      st_d = ICS_ADDR;
  end

  // Bit counter restarts whenever the phase changes.
  assign cnt_d = (st_d != st_q || ev.start) ? `ICS_BIT_FIRST :
                 (ev.scl_rise && shifting) ? cnt_q + `ICS_BIT_STEP : cnt_q;

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      st_q <= ICS_IDLE;
      cnt_q <= `ICS_BIT_FIRST;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
    end
  end

  // ****************************************************************
  // Byte shifters
  // ****************************************************************
  // Receive MSB first; transmit shifts on SCL falls inside a byte.
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      sh_q <= `ICS_ZERO_BYTE;
      tx_q <= `ICS_ZERO_BYTE;
      ld_q <= 1'b0;
    end
    else
    begin
      ld_q <= rd_prep;
      if (ev.scl_rise && (st_q == ICS_ADDR || st_q == ICS_WDATA))
        sh_q <= {sh_q[6:0], ev.sda};
      if (ld_q)
        tx_q <= read_sel(cmd_q, i_mem_rdata, off_q, addr_q);
      else if (ev.scl_fall && st_q == ICS_RDATA &&
               cnt_q != `ICS_BIT_LAST)
        tx_q <= {tx_q[6:0], 1'b0}; // see [RULE_17]
    end
  end

  // ****************************************************************
  // Command register and address/offset registers
  // ****************************************************************
  // Each byte of a frame behaves as its own single-byte frame would.
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      cmd_q <= `ICS_BIT_FIRST;
      rw_q <= 1'b0;
    end
    else if (addr_done)
    begin
      cmd_q <= sh_q[4:1]; // see [RULE_02]
      rw_q <= sh_q[0];
    end
    else if (wack_end || rack_ok)
      cmd_q <= cmd_nx; // see [RULE_13] see [RULE_14] see [RULE_15]
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      addr_q <= `ICS_ZERO_ADDR;
      off_q <= `ICS_ZERO_BYTE;
    end
    else
    begin
      if (wr_exec && cmd_q == `ICS_CMD_ADDR_HI)
        addr_q[15:8] <= sh_q; // see [RULE_05]
      if (wr_exec && cmd_q == `ICS_CMD_ADDR_LO)
        addr_q[7:0] <= sh_q; // see [RULE_05]
      if (wr_exec && cmd_q == `ICS_CMD_OFF_WR)
        off_q <= sh_q; // see [RULE_09]
      else if ((wr_exec && cmd_q == `ICS_CMD_IDX_WR) ||
               (rd_done && cmd_q == `ICS_CMD_IDX_RD))
        off_q <= off_q + `ICS_OFF_STEP; // see [RULE_08]
    end
  end

  // ****************************************************************
  // Access and instruction strobes
  // ****************************************************************
  // Unused codes reach none of these strobes.
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      mem_q <= '0;
      instruction_cmd_v_q <= 1'b0;
      instruction_cmd_q <= `ICS_ZERO_BYTE;
    end
    else
    begin
      mem_q.wr <= wr_exec && (cmd_q == `ICS_CMD_DIR_WR ||
                  cmd_q == `ICS_CMD_IDX_WR); // see [RULE_06] see [RULE_11]
      mem_q.rd <= rd_prep && (prep_cmd == `ICS_CMD_DIR_RD ||
                  prep_cmd == `ICS_CMD_IDX_RD); // see [RULE_08]
      if (wr_exec)
      begin
        mem_q.addr <= target(cmd_q, addr_q, off_q);
        mem_q.wdata <= sh_q;
      end
      else if (rd_prep)
        mem_q.addr <= target(prep_cmd, addr_q, off_q);
      instruction_cmd_v_q <= wr_exec && cmd_q == `ICS_CMD_INSTRUCTION_CMD; // see [RULE_10]
      if (wr_exec && cmd_q == `ICS_CMD_INSTRUCTION_CMD)
        instruction_cmd_q <= sh_q;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  a_chip_match_ack: assert property ($rose(st_q == ICS_AACK) |->
    ($past(sh_q[7:5]) == ev.chip) && o_sda_oe) // see [RULE_03]
    else $error("ack given to a foreign chip selector");
  a_addr_hi_load: assert property (wr_exec && cmd_q == `ICS_CMD_ADDR_HI
    |=> addr_q[15:8] == $past(sh_q)) // see [RULE_05]
    else $error("address high byte not loaded");
  a_direct_write: assert property (wr_exec && cmd_q == `ICS_CMD_DIR_WR
    |=> mem_q.wr && mem_q.addr == $past(addr_q)) // see [RULE_06]
    else $error("direct write went to wrong place");
  a_indexed_step: assert property (wr_exec && cmd_q == `ICS_CMD_IDX_WR
    |=> off_q == $past(off_q) + `ICS_OFF_STEP &&
    mem_q.addr == $past(addr_q) + {8'h00, $past(off_q)}) // see [RULE_08]
    else $error("indexed write address or step wrong");
  a_offset_load: assert property (wr_exec && cmd_q == `ICS_CMD_OFF_WR
    |=> off_q == $past(sh_q)) // see [RULE_09]
    else $error("offset not loaded");
  a_instruction_cmd_pulse: assert property (wr_exec && cmd_q == `ICS_CMD_INSTRUCTION_CMD
    |=> o_instruction_cmd_valid && o_instruction_cmd_byte == $past(sh_q) ##1 !o_instruction_cmd_valid)
    else $error("instruction strobe wrong"); // see [RULE_10]
  a_instruction_cmd_read_zero: assert property (ld_q && cmd_q == `ICS_CMD_INSTRUCTION_CMD
    |=> tx_q == `ICS_ZERO_BYTE) // see [RULE_10]
    else $error("instruction read not zero");
  a_unused_quiet: assert property (wr_exec && (cmd_q > `ICS_CMD_OFF_RD ||
    cmd_q == 4'h0) |=> !mem_q.wr && !o_instruction_cmd_valid) // see [RULE_11]
    else $error("unused command acted");
  a_cmd_advance: assert property (wack_end && !ev.start |=>
    cmd_q == ($past(ev.adv) ? $past(cmd_q) + `ICS_CMD_STEP : $past(cmd_q)))
    else $error("command did not follow mode pad"); // see [RULE_14]
  a_nack_release: assert property (st_q == ICS_RACK && ev.scl_rise &&
    ev.sda && !ev.start |=> st_q == ICS_IDLE && !o_sda_oe)
    else $error("read not ended on master nack"); // see [RULE_17]

  c_write_byte: cover property (wr_exec ##[1:400] wack_end);
  c_read_byte: cover property (rd_prep ##1 ld_q ##[1:400] rd_done);
  c_multi_adv: cover property (wack_end && ev.adv ##[1:400] wr_exec);
  c_indexed_read: cover property (rd_done && cmd_q == `ICS_CMD_IDX_RD);
endmodule // ics_command_slave

// [sim/ics_bus_master.sv]
// Behavioural two-wire bus master for the command slave.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/1ps
module ics_bus_master
#(
  parameter int HALF = 10
)
(
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_oe
);
  // ****************************************************************
  // Bus phases
  // ****************************************************************
  initial o_scl = 1'b1;
  initial o_sda_oe = 1'b0;

  // A third of the bus period; the slave wants at least two clocks here.
  task automatic half_wait();
    repeat (HALF) @(posedge i_clk);
  endtask

  // Data falls while the bus clock is high, so this also repeats.
  task automatic start();
    half_wait();
    o_sda_oe <= 1'b0;
    half_wait();
    o_scl <= 1'b1;
    half_wait();
    o_sda_oe <= 1'b1;
    half_wait();
    o_scl <= 1'b0;
  endtask

  // Data rises while the bus clock is high.
  task automatic stop();
    half_wait();
    o_sda_oe <= 1'b1;
    half_wait();
    o_scl <= 1'b1;
    half_wait();
    o_sda_oe <= 1'b0;
    half_wait();
  endtask

  // Data changes mid-low, well after the slave's hold, and is read
  // just before the falling edge.
  task automatic bit_x(input logic b, output logic r);
    half_wait();
    o_sda_oe <= ~b;
    half_wait();
    o_scl <= 1'b1;
    half_wait();
    r = i_sda;
    o_scl <= 1'b0;
  endtask

  // Eight bits first to last, then the ninth; ff releases the wire.
  task automatic byte_x(input logic [7:0] tx, input logic ack_in,
                        output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) bit_x(tx[i], rx[i]);
    bit_x(ack_in, ack);
  endtask
endmodule // ics_bus_master

// [sim/ics_command_slave_bench.sv]
// Self-checking bench for the command slave with a bus master model.
// Assumes a memory whose read data follows the held access address,
// so it is valid during and after the read strobe.
`timescale 1ns/1ps
module ics_command_slave_bench;
  import ics_pkg::*;
  // ****************************************************************
  // Stimulus, models and checks
  // ****************************************************************
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [2:0] chip = 3'h0;
  logic pad = 1'b0;
  wire [7:0] rdata;
  logic sda_oe;
  logic m_oe;
  logic scl;
  wire sda;
  ics_mem_req_t req;
  logic ins_v;
  logic [7:0] ins_b;
  int n_fail = 0;
  int n_checks = 0;
  logic [31:0] seed = 32'h0001472f;
  logic [23:0] exp_wr[$];
  logic [7:0] exp_ins[$];
  logic [15:0] addr;
  logic [15:0] ia;
  logic [7:0] off;
  logic [7:0] rx;
  logic [7:0] d;
  logic [3:0] cc;
  logic ack;

  always #25 i_clk = ~i_clk;
  // Pull-up: the wire is low while either party drives it.
  assign sda = ~(sda_oe | m_oe);

  ics_command_slave i_ics_command_slave (.i_clk(i_clk),
    .i_reset(i_reset), .i_scl(scl), .i_sda(sda),
    .i_chip_select_code(chip), .i_auto_advance_pad(pad),
    .i_mem_rdata(rdata), .o_sda_o(), .o_sda_oe(sda_oe),
    .o_mem_req(req), .o_instruction_cmd_valid(ins_v), .o_instruction_cmd_byte(ins_b));
  ics_bus_master i_ics_bus_master (.i_clk(i_clk), .i_sda(sda),
    .o_scl(scl), .o_sda_oe(m_oe));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Memory content is a hash of the address, so no storage is needed.
  function automatic logic [7:0] mem_val(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction

  // The slave loads its transmit byte while the read strobe is high,
  // so the model answers from the held address with no extra delay.
  assign rdata = mem_val(req.addr);

  task automatic chk_ack(input string n, input logic e, input logic g);
    n_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_byte(input string n, input logic [7:0] e,
                          input logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_wr(input logic [23:0] e, input logic [23:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch write expected %h seen %h", e, g);
    end
  endtask

  task automatic close_out();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic idle();
    repeat (20) @(posedge i_clk);
  endtask

  task automatic send(input logic [3:0] c, input logic rd);
    i_ics_bus_master.start();
    i_ics_bus_master.byte_x({chip, c, rd}, 1'b1, rx, ack);
    chk_ack("address ack", 1'b0, ack);
  endtask

  // A noted write is expected at address a before the byte goes out.
  task automatic wr(input logic [7:0] v, input logic note,
                    input logic [15:0] a);
    if (note) exp_wr.push_back({a, v});
    i_ics_bus_master.byte_x(v, 1'b1, rx, ack);
    chk_ack("data ack", 1'b0, ack);
  endtask

  task automatic rd(input logic [7:0] e, input logic last);
    i_ics_bus_master.byte_x(8'hff, last, rx, ack);
    chk_byte("read byte", e, rx);
  endtask

  // Strobes are matched against the oldest note; a spare one fails.
  always @(posedge i_clk)
  begin
    if (!i_reset && req.wr === 1'b1)
      chk_wr(exp_wr.size() ? exp_wr.pop_front() : 24'hx,
             {req.addr, req.wdata});
    if (!i_reset && ins_v === 1'b1)
      chk_byte("instruction", exp_ins.size() ? exp_ins.pop_front()
               : 8'hx, ins_b);
  end

  initial
  begin
    repeat (100000) @(posedge i_clk);
    n_fail++;
    close_out();
  end

  initial
  begin
    void'(xs());
    chip <= seed[2:0];
    repeat (16) @(posedge i_clk);
    i_reset <= 1'b0;
    repeat (8) @(posedge i_clk);
    // A foreign selector is left unanswered.
    i_ics_bus_master.start();
    i_ics_bus_master.byte_x({~chip, 4'h4, 1'b0}, 1'b1, rx, ack);
    chk_ack("foreign chip", 1'b1, ack);
    i_ics_bus_master.stop();
    // Advance mode: address high, low, then the write itself.
    pad <= 1'b1;
    void'(xs());
    addr = seed[15:0];
    d = seed[23:16];
    idle();
    send(4'h2, 1'b0);
    wr(addr[15:8], 1'b0, addr);
    wr(addr[7:0], 1'b0, addr);
    wr(d, 1'b1, addr);
    send(4'h3, 1'b1);
    rd(addr[7:0], 1'b0);
    rd(8'h00, 1'b0);
    rd(mem_val(addr), 1'b1);
    i_ics_bus_master.stop();
    // Repeat mode: each byte runs the same command again.
    pad <= 1'b0;
    idle();
    send(4'h4, 1'b0);
    wr(~d, 1'b1, addr);
    wr(d, 1'b1, addr);
    off = 8'h41;
    send(4'h8, 1'b0);
    wr(off, 1'b0, addr);
    ia = addr + {8'h00, off};
    send(4'h6, 1'b0);
    wr(d, 1'b1, ia);
    wr(~d, 1'b1, ia + 16'h0001);
    send(4'h9, 1'b1);
    rd(off + 8'h02, 1'b1);
    send(4'h7, 1'b1);
    rd(mem_val(ia + 16'h0002), 1'b0);
    rd(mem_val(ia + 16'h0003), 1'b1);
    send(4'h9, 1'b1);
    rd(off + 8'h04, 1'b1);
    send(4'h5, 1'b1);
    rd(mem_val(addr), 1'b1);
    exp_ins.push_back(d);
    send(4'h1, 1'b0);
    wr(d, 1'b0, addr);
    send(4'h1, 1'b1);
    rd(8'h00, 1'b1);
    i_ics_bus_master.stop();
    // Unused codes take bytes but act on nothing and read as zero.
    for (int c = 10; c <= 16; c++)
    begin
      cc = c[3:0];
      send(cc, 1'b0);
      wr(seed[7:0], 1'b0, addr);
      send(cc, 1'b1);
      rd(8'h00, 1'b1);
      i_ics_bus_master.stop();
    end
    // Single-byte frames joined by repeated starts give the same write.
    repeat (4)
    begin
      void'(xs());
      addr = seed[15:0];
      send(4'h2, 1'b0);
      wr(addr[15:8], 1'b0, addr);
      send(4'h3, 1'b0);
      wr(addr[7:0], 1'b0, addr);
      send(4'h4, 1'b0);
      wr(seed[23:16], 1'b1, addr);
      i_ics_bus_master.stop();
    end
    idle();
    chk_byte("notes left", 8'h00, 8'(exp_wr.size() + exp_ins.size()));
    close_out();
  end
endmodule // ics_command_slave_bench
